//--- cgp_regs.vh
`ifndef CGP_REGS_VH
`define CGP_REGS_VH

// ==============================================================
// Serial interface constants.
// ==============================================================
`define CGP_SLAVE_ADDR 8'hD2
`define CGP_CMD_BYTE_BIT 7
`define CGP_NUM_BYTES 7'h03
`define CGP_BLOCK_COUNT 8'h03

// ==============================================================
// APB byte addresses.
// ==============================================================
`define CGP_OFF_OUTEN0 12'h000
`define CGP_OFF_OUTEN1 12'h004
`define CGP_OFF_OUTEN2 12'h008
`define CGP_OFF_STATUS 12'h00C

// ==============================================================
// Control byte reset values and writable masks.
// ==============================================================
`define CGP_DEF0 8'h3F
`define CGP_DEF1 8'h3F
`define CGP_DEF2 8'h01
`define CGP_MASK0 8'h3F
`define CGP_MASK1 8'h3F
`define CGP_MASK2 8'h01

// ==============================================================
// Field positions.
// ==============================================================
`define CGP_EN0_PCIF_BIT 5
`define CGP_EN2_AGP_BIT 0
`define CGP_ST_LATCHED_BIT 0
`define CGP_ST_MODE_BIT 1
`define CGP_ST_PM_BIT 2
`define CGP_ST_STOP_BIT 3
`define CGP_ST_PD_BIT 4
`define CGP_ST_HALT_BIT 5

// ==============================================================
// Synchroniser lane positions.
// ==============================================================
`define CGP_SYNC_W 10
`define CGP_S_PWR 0
`define CGP_S_STRAP 1
`define CGP_S_STOP 2
`define CGP_S_HALT 3
`define CGP_S_PD 4
`define CGP_S_SCL 5
`define CGP_S_SDA 6
`define CGP_S_PCI 7
`define CGP_S_AGP 8
`define CGP_S_BUF 9

`endif

//--- cgp_sync.v
`timescale 1ns/1ns

// ==============================================================
// Two-stage synchroniser for a group of unrelated levels.
// ==============================================================
module cgp_sync #(
  parameter W = 10
) (
  input wire CLK,
  input wire RST,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta;

  // The first stage feeds only the second stage.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // cgp_sync

//--- cgp_power_ctl.v
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "cgp_regs.vh"

module cgp_power_ctl (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SUPPLY_OK,
  input wire GRAPHICS_PORT_CLOCK_IN,
  output reg GRAPHICS_PORT_CLOCK_OUT,
  output reg GRAPHICS_PORT_CLOCK_OE,
  input wire GRAPHICS_CLOCK_SOURCE,
  input wire BUS_CLOCK_STOP_N,
  input wire PROCESSOR_CLOCK_HALT_N,
  input wire POWER_DOWN_N,
  input wire SERIAL_CLOCK,
  input wire SERIAL_DATA_LINE_IN,
  output wire SERIAL_DATA_LINE_OUT,
  output reg SERIAL_DATA_LINE_OE,
  input wire BUS_CLOCK_SOURCE,
  output reg [4:0] BUS_CLOCK_OUT,
  output reg BUS_CLOCK_FREE_OUT,
  input wire DDR_BUFFER_IN,
  output reg [5:0] DDR_TRUE_OUTPUTS,
  output reg [5:0] DDR_COMP_OUTPUTS,
  output reg FEEDBACK_CLOCK_OUT,
  output reg POWER_DOWN_ACTIVE,
  output reg PROCESSOR_HALT_REQ
);

  // ==============================================================
  // Serial engine states.
  // ==============================================================
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX = 5'h02;
  localparam [4:0] ST_RACK = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_TACK = 5'h10;

  // ==============================================================
  // Declarations.
  // ==============================================================
  wire [`CGP_SYNC_W-1:0] pin_raw;
  wire [`CGP_SYNC_W-1:0] pin_s;
  reg [`CGP_SYNC_W-1:0] pin_d;
  reg [7:0] cfg [0:2];
  reg strap_latched;
  reg mode_val;
  reg [4:0] bus_gate;
  reg [4:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] byte_no;
  reg [6:0] ptr;
  reg is_read;
  reg is_block;
  reg count_due;
  reg sda_low;
  reg got_ack;
  wire pm_enabled;
  wire stop_req;
  wire pd_req;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire [7:0] rx_byte;
  wire sm_wr;
  reg [1:0] sm_wr_idx;
  reg [7:0] sm_wr_data;
  wire apb_wr;
  wire [1:0] apb_idx;
  wire apb_is_cfg;
  wire apb_hit;
  wire [7:0] status_byte;
  reg [7:0] next_tx;

  // Writable bits of each control byte.
  function [7:0] cfg_mask;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: cfg_mask = `CGP_MASK0;
        2'h1: cfg_mask = `CGP_MASK1;
        2'h2: cfg_mask = `CGP_MASK2;
        default: cfg_mask = 8'h00;
      endcase
    end
  endfunction

  // True when an index names an existing control byte.
  function in_range;
    input [6:0] idx;
    begin
      in_range = (idx < `CGP_NUM_BYTES);
    end
  endfunction

  // ==============================================================
  // Input synchronisation.
  // ==============================================================
  assign pin_raw[`CGP_S_PWR] = SUPPLY_OK;
  assign pin_raw[`CGP_S_STRAP] = GRAPHICS_PORT_CLOCK_IN;
  assign pin_raw[`CGP_S_STOP] = BUS_CLOCK_STOP_N;
  assign pin_raw[`CGP_S_HALT] = PROCESSOR_CLOCK_HALT_N;
  assign pin_raw[`CGP_S_PD] = POWER_DOWN_N;
  assign pin_raw[`CGP_S_SCL] = SERIAL_CLOCK;
  assign pin_raw[`CGP_S_SDA] = SERIAL_DATA_LINE_IN;
  assign pin_raw[`CGP_S_PCI] = BUS_CLOCK_SOURCE;
  assign pin_raw[`CGP_S_AGP] = GRAPHICS_CLOCK_SOURCE;
  assign pin_raw[`CGP_S_BUF] = DDR_BUFFER_IN;

  cgp_sync #(
    .W(`CGP_SYNC_W)
  ) u_sync (
    .CLK(CLK),
    .RST(RST),
    .d(pin_raw),
    .q(pin_s)
  );

  // Delayed copy of the synchronised pins for edge finding.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_d <= {`CGP_SYNC_W{1'b0}};
    end else begin
      pin_d <= pin_s;
    end
  end

  // ==============================================================
  // Mode strap capture.
  // ==============================================================
  // The strap is read once the supply is good, never under reset.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      strap_latched <= 1'b0;
      mode_val <= 1'b1;
    end else if (!strap_latched && pin_s[`CGP_S_PWR]) begin
      strap_latched <= 1'b1;
      mode_val <= pin_s[`CGP_S_STRAP];
    end
  end

  // Power-management pins only count with the strap latched low.
  assign pm_enabled = strap_latched && !mode_val;
  assign stop_req = pm_enabled && !pin_s[`CGP_S_STOP];
  assign pd_req = pm_enabled && !pin_s[`CGP_S_PD];

  // ==============================================================
  // Bus clock gating.
  // ==============================================================
  // The gate only changes while the source is low, so a stop lands on a
  // falling edge and a restart begins with a whole high phase.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      bus_gate <= 5'h00;
    end else if (!pin_s[`CGP_S_PCI]) begin
      bus_gate <= {5{stop_req}};
    end
  end

  // ==============================================================
  // Clock outputs.
  // ==============================================================
  // All clock outputs are registered; power-down holds them low.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUS_CLOCK_OUT <= 5'h00;
      BUS_CLOCK_FREE_OUT <= 1'b0;
      DDR_TRUE_OUTPUTS <= 6'h00;
      DDR_COMP_OUTPUTS <= 6'h00;
      FEEDBACK_CLOCK_OUT <= 1'b0;
      GRAPHICS_PORT_CLOCK_OUT <= 1'b0;
      GRAPHICS_PORT_CLOCK_OE <= 1'b0;
      POWER_DOWN_ACTIVE <= 1'b0;
      PROCESSOR_HALT_REQ <= 1'b0;
    end else begin
      POWER_DOWN_ACTIVE <= pd_req;
      PROCESSOR_HALT_REQ <= pm_enabled && !pin_s[`CGP_S_HALT];
      GRAPHICS_PORT_CLOCK_OE <= strap_latched;
      GRAPHICS_PORT_CLOCK_OUT <= strap_latched && !pd_req
        && cfg[2][`CGP_EN2_AGP_BIT] && pin_s[`CGP_S_AGP];
      BUS_CLOCK_OUT <= {5{pin_s[`CGP_S_PCI] && !pd_req}}
        & ~bus_gate & cfg[0][4:0];
      BUS_CLOCK_FREE_OUT <= pin_s[`CGP_S_PCI] && !pd_req
        && cfg[0][`CGP_EN0_PCIF_BIT];
      DDR_TRUE_OUTPUTS <= {6{pin_s[`CGP_S_BUF] && !pd_req}} & cfg[1][5:0];
      DDR_COMP_OUTPUTS <= {6{!pin_s[`CGP_S_BUF] && !pd_req}} & cfg[1][5:0];
      FEEDBACK_CLOCK_OUT <= pin_s[`CGP_S_BUF] && !pd_req;
    end
  end

  // ==============================================================
  // Serial bus conditions.
  // ==============================================================
  assign scl_rise = pin_s[`CGP_S_SCL] && !pin_d[`CGP_S_SCL];
  assign scl_fall = !pin_s[`CGP_S_SCL] && pin_d[`CGP_S_SCL];
  assign start_seen = pin_s[`CGP_S_SCL] && pin_d[`CGP_S_SCL]
    && !pin_s[`CGP_S_SDA] && pin_d[`CGP_S_SDA];
  assign stop_seen = pin_s[`CGP_S_SCL] && pin_d[`CGP_S_SCL]
    && pin_s[`CGP_S_SDA] && !pin_d[`CGP_S_SDA];
  assign rx_byte = shift;

  // The line is only ever pulled low, never driven high.
  assign SERIAL_DATA_LINE_OUT = 1'b0;

  // Open-drain enable follows the internal pull-down request.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      SERIAL_DATA_LINE_OE <= 1'b0;
    end else begin
      SERIAL_DATA_LINE_OE <= sda_low;
    end
  end

  // Next byte to send: in a block read the block count first, then control bytes.
  always @* begin
    next_tx = 8'h00;
    if (count_due) begin
      next_tx = `CGP_BLOCK_COUNT;
    end else if (in_range(ptr)) begin
      next_tx = cfg[ptr[1:0]];
    end
  end

  // A received data byte becomes a write once its ninth bit is due.
  assign sm_wr = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8)
    && !is_read && (byte_no > 8'h01) && !(is_block && byte_no == 8'h02)
    && in_range(ptr);

  // Index and data of a serial write.
  always @* begin
    sm_wr_idx = ptr[1:0];
    sm_wr_data = rx_byte;
  end

  // ==============================================================
  // Serial slave engine.
  // ==============================================================
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      byte_no <= 8'h00;
      ptr <= 7'h00;
      is_read <= 1'b0;
      is_block <= 1'b0;
      count_due <= 1'b0;
      sda_low <= 1'b0;
      got_ack <= 1'b0;
    end else if (start_seen) begin
      state <= ST_RX;
      bit_cnt <= 4'h0;
      byte_no <= 8'h00;
      sda_low <= 1'b0;
    end else if (stop_seen) begin
      state <= ST_IDLE;
      sda_low <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_low <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            shift <= {shift[6:0], pin_s[`CGP_S_SDA]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            byte_no <= byte_no + 8'h01;
            state <= ST_RACK;
            sda_low <= 1'b1;
            if (byte_no == 8'h00) begin
              if ({rx_byte[7:1], 1'b0} == `CGP_SLAVE_ADDR) begin
                is_read <= rx_byte[0];
                count_due <= rx_byte[0] && is_block;
              end else begin
                state <= ST_IDLE;
                sda_low <= 1'b0;
              end
            end else if (byte_no == 8'h01) begin
              is_block <= !rx_byte[`CGP_CMD_BYTE_BIT];
              ptr <= rx_byte[`CGP_CMD_BYTE_BIT] ? rx_byte[6:0] : 7'h00;
            end else if (!(is_block && byte_no == 8'h02)) begin
              ptr <= ptr + 7'h01;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            if (is_read) begin
              state <= ST_TX;
              shift <= next_tx;
              sda_low <= !next_tx[7];
              if (count_due) begin
                count_due <= 1'b0;
              end else begin
                ptr <= ptr + 7'h01;
              end
            end else begin
              state <= ST_RX;
              sda_low <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              sda_low <= 1'b0;
              got_ack <= 1'b0;
              state <= ST_TACK;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sda_low <= !shift[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            got_ack <= !pin_s[`CGP_S_SDA];
          end else if (scl_fall) begin
            if (got_ack && is_block) begin
              state <= ST_TX;
              shift <= next_tx;
              sda_low <= !next_tx[7];
              if (count_due) begin
                count_due <= 1'b0;
              end else begin
                ptr <= ptr + 7'h01;
              end
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // ==============================================================
  // APB slave.
  // ==============================================================
  assign PREADY = 1'b1;
  assign apb_is_cfg = (PADDR == `CGP_OFF_OUTEN0) || (PADDR == `CGP_OFF_OUTEN1)
    || (PADDR == `CGP_OFF_OUTEN2);
  assign apb_hit = apb_is_cfg || (PADDR == `CGP_OFF_STATUS);
  assign apb_idx = PADDR[3:2];
  assign PSLVERR = PSEL && PENABLE && !apb_hit;
  assign apb_wr = PSEL && PENABLE && PWRITE && apb_is_cfg;

  // Live status of the block.
  assign status_byte = {2'b00, PROCESSOR_HALT_REQ, pd_req, stop_req,
    pm_enabled, mode_val, strap_latched};

  // Read data is captured in the setup cycle and held for the access.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      if (PWRITE || !apb_hit) begin
        PRDATA <= 32'h00000000;
      end else if (apb_is_cfg) begin
        PRDATA <= {24'h000000, cfg[apb_idx]};
      end else begin
        PRDATA <= {24'h000000, status_byte};
      end
    end
  end

  // ==============================================================
  // Control bytes.
  // ==============================================================
  // A serial write wins over an APB write in the same cycle.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg[0] <= `CGP_DEF0;
      cfg[1] <= `CGP_DEF1;
      cfg[2] <= `CGP_DEF2;
    end else if (sm_wr) begin
      cfg[sm_wr_idx] <= sm_wr_data & cfg_mask(sm_wr_idx);
    end else if (apb_wr) begin
      cfg[apb_idx] <= PWDATA[7:0] & cfg_mask(apb_idx);
    end
  end

endmodule // cgp_power_ctl

//--- cgp_power_asserts.sv
`timescale 1ns/1ns

// ==============================================================
// Checker on the pins of the power-management block.
// ==============================================================
module cgp_power_asserts (
  input wire CLK,
  input wire RST,
  input wire SUPPLY_OK,
  input wire GRAPHICS_PORT_CLOCK_IN,
  input wire GRAPHICS_PORT_CLOCK_OE,
  input wire BUS_CLOCK_STOP_N,
  input wire POWER_DOWN_N,
  input wire SERIAL_CLOCK,
  input wire SERIAL_DATA_LINE_OE,
  input wire [4:0] BUS_CLOCK_OUT,
  input wire BUS_CLOCK_FREE_OUT,
  input wire [5:0] DDR_TRUE_OUTPUTS,
  input wire FEEDBACK_CLOCK_OUT,
  input wire DDR_BUFFER_IN,
  input wire POWER_DOWN_ACTIVE
);
  reg pm_on;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Tracks whether the strap is low for as long as the graphics pin is still an input.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pm_on <= 1'b0;
    end else if (!GRAPHICS_PORT_CLOCK_OE) begin
      pm_on <= !GRAPHICS_PORT_CLOCK_IN;
    end
  end

  // Pin roles and the strap.
  a_strap_after_supply: assert property ($rose(GRAPHICS_PORT_CLOCK_OE) |-> $past(SUPPLY_OK))
    else $error("graphics pin driven before supply was up");
  a_pm_mode_gate: assert property (!pm_on || !GRAPHICS_PORT_CLOCK_OE |-> !POWER_DOWN_ACTIVE)
    else $error("power-down active without strap low");
  // Power-down entry and its effect on the clocks.
  a_pd_cause: assert property ($rose(POWER_DOWN_ACTIVE) |-> !$past(POWER_DOWN_N, 2))
    else $error("power-down entered without a low request");
  a_pd_enter: assert property ((pm_on && GRAPHICS_PORT_CLOCK_OE && !POWER_DOWN_N) [*8]
    |-> POWER_DOWN_ACTIVE)
    else $error("power-down request ignored");
  a_pd_quiet: assert property (POWER_DOWN_ACTIVE [*4] |-> BUS_CLOCK_OUT == 5'h00 &&
    !FEEDBACK_CLOCK_OUT && DDR_TRUE_OUTPUTS == 6'h00)
    else $error("clock still running in power-down");
  // Bus clock stop.
  a_stop_no_rise: assert property ((pm_on && GRAPHICS_PORT_CLOCK_OE && !BUS_CLOCK_STOP_N) [*8]
    |-> (BUS_CLOCK_OUT & ~$past(BUS_CLOCK_OUT)) == 5'h00)
    else $error("stoppable bus clock rose while stopped");
  a_free_runs: assert property (!BUS_CLOCK_STOP_N && GRAPHICS_PORT_CLOCK_OE && POWER_DOWN_N &&
    !POWER_DOWN_ACTIVE && !BUS_CLOCK_FREE_OUT |-> ##[1:12] BUS_CLOCK_FREE_OUT)
    else $error("free bus clock halted");
  a_stop_ignored: assert property (!pm_on && GRAPHICS_PORT_CLOCK_OE && !BUS_CLOCK_STOP_N &&
    !BUS_CLOCK_OUT[1] |-> ##[1:12] BUS_CLOCK_OUT[1])
    else $error("bus clock stopped with strap high");
  a_restart_full: assert property ($fell(BUS_CLOCK_OUT[1]) && POWER_DOWN_N &&
    $past(POWER_DOWN_N, 8) && $past(GRAPHICS_PORT_CLOCK_OE, 8)
    |-> $past(BUS_CLOCK_OUT[1], 4) && $past(BUS_CLOCK_OUT[1], 2))
    else $error("short high pulse on a bus clock");
  // Serial data only changes while the serial clock is low.
  a_sda_scl_low: assert property ($changed(SERIAL_DATA_LINE_OE) |-> !$past(SERIAL_CLOCK))
    else $error("serial data driven while clock high");
  // The feedback copy trails the buffer input by the two sync stages and its own flop.
  a_feedback_phase: assert property (!$past(RST, 3) |-> (!DDR_TRUE_OUTPUTS[0] ||
    FEEDBACK_CLOCK_OUT) && FEEDBACK_CLOCK_OUT == ($past(DDR_BUFFER_IN, 3) && !POWER_DOWN_ACTIVE))
    else $error("feedback out of phase with true outputs");

  c_pd: cover property (POWER_DOWN_ACTIVE);
  c_stop: cover property ((pm_on && GRAPHICS_PORT_CLOCK_OE && !BUS_CLOCK_STOP_N) [*8]);
  c_stop_off: cover property (!pm_on && GRAPHICS_PORT_CLOCK_OE && !BUS_CLOCK_STOP_N);
  c_ack: cover property (SERIAL_DATA_LINE_OE);
endmodule // cgp_power_asserts

//--- cgp_smb_host.sv
`timescale 1ns/1ns

// ==============================================================
// Serial bus host: 80 ns clock, stands high between frames.
// ==============================================================
module cgp_smb_host (
  input wire CLK,
  input wire sda,
  output reg scl,
  output reg sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task start;
    cyc(2);
    sda_pull <= 1'b0;
    cyc(3);
    scl <= 1'b1;
    cyc(5);
    sda_pull <= 1'b1;
    cyc(5);
    scl <= 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus idles.
  task stop;
    cyc(2);
    sda_pull <= 1'b1;
    cyc(3);
    scl <= 1'b1;
    cyc(5);
    sda_pull <= 1'b0;
    cyc(5);
  endtask

  // One bit: data set in the low phase, line sampled at the end of the high phase.
  task xbit(input logic b, output logic v);
    cyc(2);
    sda_pull <= !b;
    cyc(3);
    scl <= 1'b1;
    cyc(5);
    v = sda;
    scl <= 1'b0;
  endtask

  // Eight bits, most significant first, then the acknowledge bit.
  task xbyte(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack);
    integer i;
    for (i = 7; i >= 0; i--) xbit(b[i], r[i]);
    xbit(last, ack);
  endtask
endmodule // cgp_smb_host

//--- tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

// ==============================================================
// Testbench for the power-management block.
// ==============================================================
module tb_top;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic SUPPLY_OK = 1'b0, GRAPHICS_CLOCK_SOURCE = 1'b0, BUS_CLOCK_STOP_N = 1'b1;
  logic PROCESSOR_CLOCK_HALT_N = 1'b1, POWER_DOWN_N = 1'b1, BUS_CLOCK_SOURCE = 1'b0;
  logic DDR_BUFFER_IN = 1'b0, strap = 1'b0;
  logic [2:0] src_cnt = 3'h0;
  logic [31:0] rdata;
  logic rerr;
  logic [6:0] seen;
  logic [12:0] seen_x;
  int n_mismatch = 0, num_checks = 0, tick = 0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, gp_out, gp_oe, sda_out, sda_oe, free_out, fb_out, pd_act, halt_req;
  wire [4:0] bus_out;
  wire [5:0] ddr_t, ddr_c;
  wire scl, host_pull;
  wire sda_line = ~(host_pull | sda_oe);
  wire gp_pin = gp_oe ? gp_out : strap;

  cgp_power_ctl u_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SUPPLY_OK(SUPPLY_OK), .GRAPHICS_PORT_CLOCK_IN(gp_pin), .GRAPHICS_PORT_CLOCK_OUT(gp_out),
    .GRAPHICS_PORT_CLOCK_OE(gp_oe), .GRAPHICS_CLOCK_SOURCE(GRAPHICS_CLOCK_SOURCE),
    .BUS_CLOCK_STOP_N(BUS_CLOCK_STOP_N), .PROCESSOR_CLOCK_HALT_N(PROCESSOR_CLOCK_HALT_N),
    .POWER_DOWN_N(POWER_DOWN_N), .SERIAL_CLOCK(scl), .SERIAL_DATA_LINE_IN(sda_line),
    .SERIAL_DATA_LINE_OUT(sda_out), .SERIAL_DATA_LINE_OE(sda_oe),
    .BUS_CLOCK_SOURCE(BUS_CLOCK_SOURCE), .BUS_CLOCK_OUT(bus_out), .BUS_CLOCK_FREE_OUT(free_out),
    .DDR_BUFFER_IN(DDR_BUFFER_IN), .DDR_TRUE_OUTPUTS(ddr_t), .DDR_COMP_OUTPUTS(ddr_c),
    .FEEDBACK_CLOCK_OUT(fb_out), .POWER_DOWN_ACTIVE(pd_act), .PROCESSOR_HALT_REQ(halt_req));

  cgp_smb_host u_host (.CLK(CLK), .sda(sda_line), .scl(scl), .sda_pull(host_pull));

  always #4 CLK = ~CLK;

  // Clock sources for the outputs, and the run's ceiling.
  always @(posedge CLK) begin
    src_cnt <= src_cnt + 3'h1;
    BUS_CLOCK_SOURCE <= src_cnt[2];
    DDR_BUFFER_IN <= src_cnt[1];
    GRAPHICS_CLOCK_SOURCE <= src_cnt[0];
    tick <= tick + 1;
    if (tick == 30000) begin
      n_mismatch++;
      finish_test;
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  task power_up(input logic s);
    strap <= s;
    SUPPLY_OK <= 1'b0;
    RST <= 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    SUPPLY_OK <= 1'b1;
    repeat (10) @(posedge CLK);
  endtask

  // One APB transfer, held until ready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK("read data", e, rdata)
    `CHK("read error", 1'b0, rerr)
  endtask

  // One serial byte; the echo and the acknowledge are compared.
  task sb(input logic [7:0] b, input logic last, input logic [7:0] er, input logic ea);
    logic [7:0] r;
    logic ack;
    u_host.xbyte(b, last, r, ack);
    `CHK("serial byte", er, r)
    `CHK("serial ack", ea, ack)
  endtask

  // Collects which bus and feedback clock outputs went high over n cycles.
  task watch(input int n, input logic [6:0] e);
    seen = 7'h00;
    repeat (n) begin
      @(posedge CLK);
      seen = seen | {fb_out, free_out, bus_out};
    end
    `CHK("clocks seen", e, seen)
  endtask

  // Collects which graphics and memory clock outputs went high over n cycles.
  task watch_x(input int n, input logic [12:0] e);
    seen_x = 13'h0000;
    repeat (n) begin
      @(posedge CLK);
      seen_x = seen_x | {gp_out, ddr_c, ddr_t};
    end
    `CHK("outputs seen", e, seen_x)
  endtask

  initial begin
    power_up(1'b0);
    rdchk(12'h000, 32'h0000003F);
    rdchk(12'h004, 32'h0000003F);
    rdchk(12'h008, 32'h00000001);
    apb(1'b1, 12'h00C, 32'h000000FF);
    rdchk(12'h00C, 32'h00000005);
    `CHK("graphics oe", 1'b1, gp_oe)
    `CHK("serial data out", 1'b0, sda_out)
    apb(1'b0, 12'h010, 32'h00000000);
    `CHK("unmapped error", 1'b1, rerr)
    watch(40, 7'h7F);
    watch_x(40, 13'h1FFF);
    done("defaults");
    u_host.start;
    sb(8'hD2, 1'b1, 8'hD2, 1'b0);
    sb(8'h80, 1'b1, 8'h80, 1'b0);
    sb(8'h3E, 1'b1, 8'h3E, 1'b0);
    u_host.stop;
    rdchk(12'h000, 32'h0000003E);
    watch(40, 7'h7E);
    u_host.start;
    sb(8'hA0, 1'b1, 8'hA0, 1'b1);
    u_host.stop;
    apb(1'b1, 12'h004, 32'h00000015);
    watch_x(40, 13'h1555);
    u_host.start;
    sb(8'hD2, 1'b1, 8'hD2, 1'b0);
    sb(8'h81, 1'b1, 8'h81, 1'b0);
    u_host.start;
    sb(8'hD3, 1'b1, 8'hD3, 1'b0);
    sb(8'hFF, 1'b1, 8'h15, 1'b1);
    u_host.stop;
    done("byte access");
    u_host.start;
    sb(8'hD2, 1'b1, 8'hD2, 1'b0);
    sb(8'h00, 1'b1, 8'h00, 1'b0);
    u_host.start;
    sb(8'hD3, 1'b1, 8'hD3, 1'b0);
    sb(8'hFF, 1'b0, 8'h03, 1'b0);
    sb(8'hFF, 1'b0, 8'h3E, 1'b0);
    sb(8'hFF, 1'b0, 8'h15, 1'b0);
    sb(8'hFF, 1'b1, 8'h01, 1'b1);
    u_host.stop;
    u_host.start;
    sb(8'hD2, 1'b1, 8'hD2, 1'b0);
    sb(8'h00, 1'b1, 8'h00, 1'b0);
    sb(8'h03, 1'b1, 8'h03, 1'b0);
    sb(8'h3F, 1'b1, 8'h3F, 1'b0);
    u_host.stop;
    rdchk(12'h000, 32'h0000003F);
    done("block access");
    BUS_CLOCK_STOP_N <= 1'b0;
    repeat (16) @(posedge CLK);
    watch(40, 7'h60);
    BUS_CLOCK_STOP_N <= 1'b1;
    repeat (16) @(posedge CLK);
    watch(40, 7'h7F);
    done("bus clock stop");
    POWER_DOWN_N <= 1'b0;
    repeat (10) @(posedge CLK);
    `CHK("power-down flag", 1'b1, pd_act)
    rdchk(12'h00C, 32'h00000015);
    watch(40, 7'h00);
    watch_x(40, 13'h0000);
    POWER_DOWN_N <= 1'b1;
    PROCESSOR_CLOCK_HALT_N <= 1'b0;
    repeat (10) @(posedge CLK);
    `CHK("halt request", 1'b1, halt_req)
    PROCESSOR_CLOCK_HALT_N <= 1'b1;
    done("power-down");
    BUS_CLOCK_STOP_N <= 1'b0;
    POWER_DOWN_N <= 1'b0;
    power_up(1'b1);
    rdchk(12'h00C, 32'h00000003);
    watch(40, 7'h7F);
    `CHK("power-down flag", 1'b0, pd_act)
    done("strap high");
    finish_test;
  end
endmodule // tb_top

bind cgp_power_ctl cgp_power_asserts u_chk (.CLK(CLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK),
  .GRAPHICS_PORT_CLOCK_IN(GRAPHICS_PORT_CLOCK_IN), .GRAPHICS_PORT_CLOCK_OE(GRAPHICS_PORT_CLOCK_OE),
  .BUS_CLOCK_STOP_N(BUS_CLOCK_STOP_N), .POWER_DOWN_N(POWER_DOWN_N), .SERIAL_CLOCK(SERIAL_CLOCK),
  .SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE), .BUS_CLOCK_OUT(BUS_CLOCK_OUT),
  .BUS_CLOCK_FREE_OUT(BUS_CLOCK_FREE_OUT), .DDR_TRUE_OUTPUTS(DDR_TRUE_OUTPUTS),
  .FEEDBACK_CLOCK_OUT(FEEDBACK_CLOCK_OUT), .POWER_DOWN_ACTIVE(POWER_DOWN_ACTIVE),
  .DDR_BUFFER_IN(DDR_BUFFER_IN));
